// file: common/scan_pkg.sv
// Package of constants and types for the external scan sequencer
package scan_pkg;
  localparam int unsigned SLOTS = 3;
  localparam int unsigned CH_PER_SLOT = 20;
  localparam int unsigned NCH = 60;
  localparam int unsigned CH_W = 6;
  localparam int unsigned CNT_W = 16;
  // Settle time in ns, counted in cycles of the 100 ns clock
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SETTLE_NS = 1000;
  localparam int unsigned SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] SETTLE_CNT = CNT_W'(SETTLE_CYC);
  localparam logic [CNT_W-1:0] PULSE_RESET = 16'h0001;
  localparam logic [CNT_W-1:0] SWEEPS_RESET = 16'h0001;
  localparam logic [CH_W-1:0] PAIR_OFS_WIDE = 6'h0a;
  localparam logic [CH_W-1:0] PAIR_OFS_NARROW = 6'h08;
  typedef enum logic [1:0] {
    SRC_TIMER = 2'b00,
    SRC_EXT = 2'b01,
    SRC_BUS = 2'b10,
    SRC_ALARM = 2'b11
  } src_e;
  typedef enum logic [1:0] {
    KIND_NONE = 2'b00,
    KIND_MUX = 2'b01,
    KIND_DIGITAL = 2'b10
  } kind_e;
endpackage

// file: common/settle_if.sv
// Interface between the sequencer and its settle timer
`timescale 1ns/1ps
interface settle_if;
  logic start;
  logic [scan_pkg::CNT_W-1:0] delay;
  logic [scan_pkg::CNT_W-1:0] width;
  logic settled;
  logic busy;
  modport seq (output start, output delay, output width, input settled, input busy);
  modport tmr (input start, input delay, input width, output settled, output busy);
endinterface

// file: logic/external_scan_sequencer.sv
// External scan sequencer: steps the scan list under an outside instrument
`timescale 1ns/1ps
module external_scan_sequencer (
  input wire mclk,
  input wire rst_b,
  input wire logic meter_present,
  input wire logic meter_enable,
  input wire logic [scan_pkg::NCH-1:0] scan_list,
  input wire logic [2*scan_pkg::NCH-1:0] channel_kind,
  input wire logic [scan_pkg::SLOTS-1:0] slot_narrow_pair,
  input wire logic four_wire_pairing,
  input wire logic [1:0] sweep_start_source_select,
  input wire logic sweep_start_source_valid,
  input wire logic [1:0] step_source_select,
  input wire logic step_source_write,
  input wire logic [scan_pkg::CNT_W-1:0] sweep_count_setting,
  input wire logic [scan_pkg::CNT_W-1:0] channel_delay,
  input wire logic [scan_pkg::CNT_W-1:0] strobe_width,
  input wire logic scan_init,
  input wire logic scan_abort,
  input wire logic [3:0] source_events,
  input wire logic trigger_in,
  output logic settled_strobe,
  output logic [scan_pkg::CH_W-1:0] close_channel,
  output logic [scan_pkg::CH_W-1:0] sense_channel,
  output logic close_valid,
  output logic sense_valid,
  output logic digital_read,
  output logic [scan_pkg::SLOTS-1:0] digital_slot,
  output logic mux_store_en,
  output logic scan_running,
  output logic config_error,
  output logic [1:0] active_start_source,
  output logic [1:0] active_step_source,
  output logic [scan_pkg::CNT_W-1:0] sweeps_done
);
  // ------------------------------------------------------------
  // Input synchronisers for the trigger pin
  // ------------------------------------------------------------
  logic trig_s1_reg;
  logic trig_s2_reg;
  logic trig_s3_reg;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      trig_s1_reg <= 1'b0;
      trig_s2_reg <= 1'b0;
      trig_s3_reg <= 1'b0;
    end else begin
      trig_s1_reg <= trigger_in;
      trig_s2_reg <= trig_s1_reg;
      trig_s3_reg <= trig_s2_reg;
    end
  end
  // Rising edge of the external trigger, taken from synchronised stages only
  logic ext_edge;
  assign ext_edge = trig_s2_reg & ~trig_s3_reg;

  // ------------------------------------------------------------
  // Source selection
  // ------------------------------------------------------------
  logic meter_off;
  assign meter_off = ~meter_present | ~meter_enable;
  logic [1:0] start_src_reg;
  logic [1:0] start_src_next;
  logic [1:0] step_src_reg;
  logic [1:0] step_src_next;
  logic err_reg;
  logic err_next;

  always_comb begin
    start_src_next = start_src_reg;
    step_src_next = step_src_reg;
    err_next = err_reg;
    if (scan_init) begin
      err_next = 1'b0;
    end
    if (sweep_start_source_valid) begin
      start_src_next = sweep_start_source_select;
    end else if (meter_off) begin
      start_src_next = scan_pkg::SRC_TIMER;
    end
    if (step_source_write) begin
      if (step_source_select == start_src_next) begin
        err_next = 1'b1;
      end else begin
        step_src_next = step_source_select;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      start_src_reg <= scan_pkg::SRC_TIMER;
      step_src_reg <= scan_pkg::SRC_EXT;
      err_reg <= 1'b0;
    end else begin
      start_src_reg <= start_src_next;
      step_src_reg <= step_src_next;
      err_reg <= err_next;
    end
  end

  // Per-source event, trigger pin replaces the external bit
  logic [3:0] ev;
  assign ev = {source_events[3:2], ext_edge, source_events[0]};
  logic start_ev;
  logic step_ev;
  assign start_ev = ev[start_src_reg];
  assign step_ev = ev[step_src_reg];

  // ------------------------------------------------------------
  // Next-channel search
  // ------------------------------------------------------------
  logic [scan_pkg::CH_W-1:0] ch_reg;
  logic [scan_pkg::CH_W-1:0] ch_next;
  logic [scan_pkg::NCH-1:0] later_mask;
  logic [scan_pkg::NCH-1:0] eligible;
  logic [scan_pkg::NCH-1:0] dig_seen;
  genvar gi;
  generate
    for (gi = 0; gi < scan_pkg::NCH; gi++) begin : g_elig
      // Digital channels after the first of their slot are folded into it
      logic is_dig;
      logic dig_follow;
      assign is_dig = (channel_kind[2*gi +: 2] == scan_pkg::KIND_DIGITAL);
      if ((gi % scan_pkg::CH_PER_SLOT) == 0) begin : g_first
        assign dig_follow = 1'b0;
        assign dig_seen[gi] = is_dig & scan_list[gi];
      end else begin : g_rest
        assign dig_follow = is_dig & dig_seen[gi-1];
        assign dig_seen[gi] = (is_dig & scan_list[gi]) | dig_seen[gi-1];
      end
      assign eligible[gi] = scan_list[gi] & (channel_kind[2*gi +: 2] != scan_pkg::KIND_NONE)
                            & ~dig_follow;
    end
  endgenerate

  logic [scan_pkg::CH_W-1:0] found_idx;
  logic found;
  always_comb begin
    found = 1'b0;
    found_idx = '0;
    // Ascending priority search; lowest index first
    for (int i = scan_pkg::NCH - 1; i >= 0; i--) begin
      if (eligible[i] && later_mask[i]) begin
        found = 1'b1;
        found_idx = scan_pkg::CH_W'(i);
      end
    end
  end

  // ------------------------------------------------------------
  // Scan state machine
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ARM = 3'b001,
    S_SEEK = 3'b010,
    S_SETTLE = 3'b011,
    S_WAIT_STEP = 3'b100
  } state_e;
  state_e st_reg;
  state_e st_next;
  logic from_start_reg;
  logic from_start_next;
  logic [scan_pkg::CNT_W-1:0] sweeps_reg;
  logic [scan_pkg::CNT_W-1:0] sweeps_next;
  logic [scan_pkg::CNT_W-1:0] target_reg;
  logic [scan_pkg::CNT_W-1:0] target_next;
  logic close_v_reg;
  logic close_v_next;

  settle_if sif ();
  settle_timer u_settle (
    .mclk(mclk),
    .rst_b(rst_b),
    .sif(sif)
  );

  generate
    for (gi = 0; gi < scan_pkg::NCH; gi++) begin : g_mask
      // From the start: all channels; otherwise only those above the current one
      assign later_mask[gi] = from_start_reg | (gi > ch_reg);
    end
  endgenerate

  always_comb begin
    st_next = st_reg;
    ch_next = ch_reg;
    from_start_next = from_start_reg;
    sweeps_next = sweeps_reg;
    target_next = target_reg;
    close_v_next = close_v_reg;
    sif.start = 1'b0;
    case (st_reg)
      S_IDLE: begin
        // Only allowed with the meter out of the path and a clean source pair
        if (scan_init && meter_off && !err_reg) begin
          st_next = S_ARM;
          sweeps_next = '0;
          target_next = (sweep_count_setting == 16'h0000) ? scan_pkg::SWEEPS_RESET : sweep_count_setting;
        end
      end
      S_ARM: begin
        if (start_ev) begin
          st_next = S_SEEK;
          from_start_next = 1'b1;
        end
      end
      S_SEEK: begin
        from_start_next = 1'b0;
        close_v_next = 1'b0;
        if (found) begin
          ch_next = found_idx;
          close_v_next = 1'b1;
          sif.start = 1'b1;
          st_next = S_SETTLE;
        end else begin
          sweeps_next = sweeps_reg + 16'h0001;
          st_next = (sweeps_reg + 16'h0001 >= target_reg) ? S_IDLE : S_ARM;
        end
      end
      S_SETTLE: begin
        // Step requests before the strobe are dropped
        if (sif.settled) begin
          st_next = S_WAIT_STEP;
        end
      end
      S_WAIT_STEP: begin
        if (step_ev && !sif.busy) begin
          close_v_next = 1'b0;
          st_next = S_SEEK;
        end
      end
      default: st_next = S_IDLE;
    endcase
    if (scan_abort || (st_reg != S_IDLE && !meter_off)) begin
      st_next = S_IDLE;
      close_v_next = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_reg <= S_IDLE;
      ch_reg <= '0;
      from_start_reg <= 1'b1;
      sweeps_reg <= '0;
      target_reg <= scan_pkg::SWEEPS_RESET;
      close_v_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      ch_reg <= ch_next;
      from_start_reg <= from_start_next;
      sweeps_reg <= sweeps_next;
      target_reg <= target_next;
      close_v_reg <= close_v_next;
    end
  end

  assign sif.delay = channel_delay;
  assign sif.width = (strobe_width == 16'h0000) ? scan_pkg::PULSE_RESET : strobe_width;

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  logic [scan_pkg::CH_W-1:0] slot_idx;
  logic [scan_pkg::CH_W-1:0] pair_ofs;
  logic ch_dig;
  always_comb begin
    slot_idx = (ch_reg >= 6'h28) ? 6'h02 : ((ch_reg >= 6'h14) ? 6'h01 : 6'h00);
    pair_ofs = slot_narrow_pair[slot_idx[1:0]] ? scan_pkg::PAIR_OFS_NARROW : scan_pkg::PAIR_OFS_WIDE;
    ch_dig = (channel_kind[2*ch_reg +: 2] == scan_pkg::KIND_DIGITAL);
  end

  assign settled_strobe = sif.settled;
  assign close_channel = ch_reg;
  assign close_valid = close_v_reg & ~ch_dig;
  assign sense_channel = ch_reg + pair_ofs;
  assign sense_valid = close_v_reg & ~ch_dig & four_wire_pairing;
  // Whole digital slot read on a single step
  assign digital_read = close_v_reg & ch_dig & sif.settled;
  assign digital_slot = close_v_reg & ch_dig ? (3'b001 << slot_idx[1:0]) : 3'b000;
  // Mux readings never stored while the meter is out of the path
  assign mux_store_en = 1'b0;
  assign scan_running = (st_reg != S_IDLE);
  assign config_error = err_reg;
  assign active_start_source = start_src_reg;
  assign active_step_source = step_src_reg;
  assign sweeps_done = sweeps_reg;
endmodule

// file: logic/settle_timer.sv
// Relay settle timer and settled-strobe generator
`timescale 1ns/1ps
module settle_timer (
  input wire mclk,
  input wire rst_b,
  settle_if.tmr sif
);
  // ------------------------------------------------------------
  // Wait then pulse
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    T_IDLE = 2'b00,
    T_WAIT = 2'b01,
    T_PULSE = 2'b10
  } tstate_e;
  tstate_e st_reg;
  tstate_e st_next;
  logic [scan_pkg::CNT_W-1:0] cnt_reg;
  logic [scan_pkg::CNT_W-1:0] cnt_next;
  logic settled_reg;
  logic settled_next;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    settled_next = 1'b0;
    case (st_reg)
      T_IDLE: begin
        if (sif.start) begin
          st_next = T_WAIT;
          cnt_next = scan_pkg::SETTLE_CNT + sif.delay;
        end
      end
      T_WAIT: begin
        if (cnt_reg <= 16'h0001) begin
          st_next = T_PULSE;
          cnt_next = (sif.width == 16'h0000) ? 16'h0001 : sif.width;
          settled_next = 1'b1;
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      T_PULSE: begin
        if (cnt_reg <= 16'h0001) begin
          st_next = T_IDLE;
        end else begin
          cnt_next = cnt_reg - 16'h0001;
          settled_next = 1'b1;
        end
      end
      default: st_next = T_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_reg <= T_IDLE;
      cnt_reg <= 16'h0000;
      settled_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      settled_reg <= settled_next;
    end
  end

  assign sif.settled = settled_reg;
  assign sif.busy = (st_reg != T_IDLE);
endmodule

// file: verification/ext_meter_model.sv
// Outside instrument model answering each settled strobe with a step request
`timescale 1ns/1ps
module ext_meter_model (
  input wire mclk,
  input wire logic settled_strobe,
  input wire logic [7:0] lag,
  output logic trigger_in
);
  // ----------------------------------------
  // Measure, then request the next channel
  // ----------------------------------------
  initial trigger_in = 1'b0;
  // Only after a full strobe, so reset edges never fake a request
  always begin
    @(posedge settled_strobe);
    @(negedge settled_strobe);
    repeat (lag) @(posedge mclk);
    #1 trigger_in = 1'b1;
    // Long enough to pass the input synchroniser
    repeat (4) @(posedge mclk);
    #1 trigger_in = 1'b0;
  end
endmodule

// file: verification/scan_monitor.sv
// Port checker for the external scan sequencer
`timescale 1ns/1ps
module scan_monitor (
  input wire mclk,
  input wire rst_b,
  input wire logic meter_present,
  input wire logic meter_enable,
  input wire logic [59:0] scan_list,
  input wire logic [2:0] slot_narrow_pair,
  input wire logic [1:0] step_source_select,
  input wire logic step_source_write,
  input wire logic [15:0] strobe_width,
  input wire logic trigger_in,
  input wire logic settled_strobe,
  input wire logic [5:0] close_channel,
  input wire logic [5:0] sense_channel,
  input wire logic close_valid,
  input wire logic sense_valid,
  input wire logic digital_read,
  input wire logic mux_store_en,
  input wire logic scan_running,
  input wire logic config_error,
  input wire logic [1:0] active_start_source,
  input wire logic [1:0] active_step_source
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic [15:0] wcnt;
  logic [5:0] ofs;
  assign ofs = slot_narrow_pair[close_channel >= 6'h28 ? 2 : close_channel >= 6'h14 ? 1 : 0] ? 6'h08 : 6'h0a;
  always_ff @(posedge mclk) wcnt <= (!rst_b || !settled_strobe) ? 16'h0000 : wcnt + 16'h0001;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_step;
    $rose(trigger_in) && close_valid && !settled_strobe;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_order;
    close_valid && !$past(close_valid) && $past(close_valid, 2) |-> close_channel > $past(close_channel);
  endproperty
  a_order: assert property (p_order) else $error("channel order went down");
  property p_listed;
    close_valid && !digital_read |-> scan_list[close_channel];
  endproperty
  a_listed: assert property (p_listed) else $error("unlisted channel closed");
  property p_no_store;
    !mux_store_en;
  endproperty
  a_no_store: assert property (p_no_store) else $error("mux reading stored");
  property p_meter_on;
    meter_present && meter_enable |-> ##[1:3] !scan_running;
  endproperty
  a_meter_on: assert property (p_meter_on) else $error("scan runs with meter on");
  property p_settle;
    $rose(settled_strobe) && !digital_read |-> $past(close_valid, 10) && $past(close_channel, 10) == close_channel;
  endproperty
  a_settle: assert property (p_settle) else $error("strobe before settle time");
  property p_step;
    s_step |-> ##[2:8] ($changed(close_channel) || !close_valid);
  endproperty
  a_step: assert property (p_step) else $error("step request not taken");
  property p_err;
    step_source_write && step_source_select == active_start_source |-> ##[1:2] config_error;
  endproperty
  a_err: assert property (p_err) else $error("equal sources not flagged");
  property p_keep;
    $rose(config_error) |-> active_step_source != active_start_source;
  endproperty
  a_keep: assert property (p_keep) else $error("bad step source taken");
  property p_dig;
    digital_read |-> settled_strobe && !close_valid && !sense_valid;
  endproperty
  a_dig: assert property (p_dig) else $error("digital read outside strobe");
  property p_pair;
    sense_valid |-> close_valid && sense_channel == close_channel + ofs;
  endproperty
  a_pair: assert property (p_pair) else $error("wrong sense partner");
  property p_width;
    $fell(settled_strobe) |-> wcnt == (strobe_width == 16'h0000 ? 16'h0001 : strobe_width);
  endproperty
  a_width: assert property (p_width) else $error("strobe width wrong");
endmodule
bind external_scan_sequencer scan_monitor u_scan_monitor (.mclk(mclk), .rst_b(rst_b),
  .meter_present(meter_present), .meter_enable(meter_enable), .scan_list(scan_list),
  .slot_narrow_pair(slot_narrow_pair), .step_source_select(step_source_select),
  .step_source_write(step_source_write), .strobe_width(strobe_width), .trigger_in(trigger_in),
  .settled_strobe(settled_strobe), .close_channel(close_channel), .sense_channel(sense_channel),
  .close_valid(close_valid), .sense_valid(sense_valid), .digital_read(digital_read),
  .mux_store_en(mux_store_en), .scan_running(scan_running), .config_error(config_error),
  .active_start_source(active_start_source), .active_step_source(active_step_source));

// file: verification/tb.sv
// Self-checking testbench for the external scan sequencer
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0;
  logic rst_b, meter_present, meter_enable, four_wire_pairing, step_source_write, scan_init, trigger_in;
  logic settled_strobe, close_valid, sense_valid, digital_read, mux_store_en, scan_running, config_error;
  logic [59:0] scan_list;
  logic [119:0] channel_kind;
  logic [2:0] slot_narrow_pair, digital_slot;
  logic [1:0] step_source_select, active_start_source, active_step_source;
  logic [15:0] sweep_count_setting, channel_delay, strobe_width, sweeps_done;
  logic [5:0] close_channel, sense_channel;
  logic [3:0] source_events = 4'h0;
  logic [7:0] lag;
  logic [13:0] expq[$];
  logic [13:0] exp_e;
  logic [15:0] seen_e;
  logic [1:0] sweep_start_source_select = 2'h0;
  logic sweep_start_source_valid = 1'b0;
  logic prev = 1'b0;
  int fail_count = 0;
  int comparisons = 0;
  always #50 mclk = ~mclk;
  external_scan_sequencer u_external_scan_sequencer (.mclk(mclk), .rst_b(rst_b),
    .meter_present(meter_present), .meter_enable(meter_enable), .scan_list(scan_list),
    .channel_kind(channel_kind), .slot_narrow_pair(slot_narrow_pair), .four_wire_pairing(four_wire_pairing),
    .sweep_start_source_select(sweep_start_source_select), .sweep_start_source_valid(sweep_start_source_valid),
    .step_source_select(step_source_select), .step_source_write(step_source_write),
    .sweep_count_setting(sweep_count_setting), .channel_delay(channel_delay), .strobe_width(strobe_width),
    .scan_init(scan_init), .scan_abort(1'b0), .source_events(source_events), .trigger_in(trigger_in),
    .settled_strobe(settled_strobe), .close_channel(close_channel), .sense_channel(sense_channel),
    .close_valid(close_valid), .sense_valid(sense_valid), .digital_read(digital_read),
    .digital_slot(digital_slot), .mux_store_en(mux_store_en), .scan_running(scan_running),
    .config_error(config_error), .active_start_source(active_start_source),
    .active_step_source(active_step_source), .sweeps_done(sweeps_done));
  ext_meter_model u_ext_meter_model (.mclk(mclk), .settled_strobe(settled_strobe), .lag(lag),
    .trigger_in(trigger_in));
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      fail_count++;
    end
  endtask
  task end_of_test;
    if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task pulse_init;
    scan_init = 1'b1;
    @(negedge mclk);
    scan_init = 1'b0;
    repeat (3) @(negedge mclk);
  endtask
  // Timer source fires at random, also while a scan is busy
  always @(negedge mclk) source_events <= {3'h0, ($urandom % 40) == 0};
  // Each strobe takes the oldest expected entry
  always @(negedge mclk) begin
    if (rst_b === 1'b1 && settled_strobe === 1'b1 && prev === 1'b0) begin
      if (expq.size() == 0) chk(16'h0001, 16'h0000);
      else begin
        exp_e = expq.pop_front();
        seen_e = {2'h0, sense_valid, sense_channel & {6{sense_valid}}, 7'h00};
        seen_e[6:0] = digital_read ? {4'h8, digital_slot} : {~close_valid, close_channel};
        chk(seen_e, {2'h0, exp_e});
      end
    end
    prev <= settled_strobe;
  end
  task run(input logic fw, input logic [15:0] n);
    int s, c, i;
    logic first;
    scan_list = 60'({$urandom, $urandom});
    four_wire_pairing = fw;
    slot_narrow_pair = 3'($urandom);
    strobe_width = 16'($urandom % 4);
    channel_delay = 16'($urandom % 5);
    lag = 8'($urandom % 6);
    sweep_count_setting = n;
    // Partners stay out of the list when pairing
    if (fw) for (c = 0; c < 60; c++) if (c % 20 >= 8) scan_list[c] = 1'b0;
    for (s = 0; s < (n == 0 ? 1 : n); s++) begin
      first = 1'b1;
      for (c = 0; c < 60; c++) if (scan_list[c]) begin
        if (channel_kind[2*c+:2] == 2'h2) begin
          if (first) expq.push_back(14'h0044);
          first = 1'b0;
        end
        else expq.push_back({fw, fw ? 6'(c + (slot_narrow_pair[c / 20] ? 8 : 10)) : 6'h00, 7'(c)});
      end
    end
    pulse_init();
    for (i = 0; i < 30000 && scan_running !== 1'b0; i++) @(negedge mclk);
    if (i == 30000) begin
      fail_count++;
      end_of_test();
    end
    chk(sweeps_done, n == 16'h0 ? 16'h1 : n);
    chk(16'(expq.size()), 16'h0);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(54));
    {rst_b, meter_present, four_wire_pairing, step_source_write, scan_init} = 5'h00;
    meter_enable = 1'b1;
    channel_kind = {60{2'h1}};
    channel_kind[100+:8] = 8'haa;
    {scan_list, slot_narrow_pair, lag} = '0;
    step_source_select = 2'h1;
    {sweep_count_setting, channel_delay, strobe_width} = '0;
    repeat (16) @(negedge mclk);
    rst_b = 1'b1;
    @(negedge mclk);
    chk(active_start_source, 16'h0);
    chk(active_step_source, 16'h1);
    run(1'b0, 16'h0000);
    run(1'b1, 16'h0002);
    sweep_start_source_select = 2'h2;
    sweep_start_source_valid = 1'b1;
    @(negedge mclk);
    sweep_start_source_valid = 1'b0;
    chk(active_start_source, 16'h2);
    @(negedge mclk);
    chk(active_start_source, 16'h0);
    chk(mux_store_en, 16'h0);
    // Meter present and on refuses a scan
    meter_present = 1'b1;
    pulse_init();
    chk(scan_running, 16'h0);
    step_source_select = 2'h0;
    step_source_write = 1'b1;
    @(negedge mclk);
    step_source_write = 1'b0;
    repeat (2) @(negedge mclk);
    chk(config_error, 16'h1);
    chk(active_step_source, 16'h1);
    end_of_test();
  end
endmodule
